// ---- core/fpe_cmd.v ----
`timescale 1ns/1ps
`default_nettype none
`include "fpe_defines.vh"

// Contract
// - quad program takes 256 bytes over four lines
// - program into protected page is silently ignored
// - program starts only on clean select rise
// - in-progress reads 1 while busy, else 0
// - page overflow wraps, last 256 bytes kept
// - partial page leaves other bytes unchanged
// - program clears bits only; erase sets them
// - erase fills 4K sector or 32/64K block
// - sector erase: opcode, three address bytes
// - block erase 52h/D8h starts at select rise
// - chip erase opcode alone erases whole array
// - chip erase needs protect zero, else flags
// - 06h sets latch, reset clears it
// - write-class commands need the latch set
// - latch clears when write operation finishes
// - 04h clears latch and blocks writes
// - 05h returns status, usable while busy
// - 01h writes protect, write-disable, quad bits
// - 48h returns function register
// - 42h sets one-time lock and reset-disable bits only
// - four-wire mode carries every command nibble-wide
module fpe_cmd (
    // clock and reset
    input wire core_clk,
    input wire arst_n,
    // serial link pins
    input wire cs_n,
    input wire sclk,
    input wire [3:0] io_in,
    output reg [3:0] io_out,
    output reg [3:0] io_oe,
    // array program port
    output reg arr_wr_valid,
    input wire arr_wr_ready,
    output reg [`FPE_AW-1:0] arr_wr_addr,
    output reg [7:0] arr_wr_data,
    // array erase port
    output reg arr_erase_req,
    output reg [`FPE_AW-1:0] arr_erase_base,
    output reg [`FPE_AW-1:0] arr_erase_mask,
    input wire arr_erase_done,
    // status view
    output reg operation_in_progress,
    output reg write_enable_latch,
    output reg quad_enable,
    output reg [3:0] block_protect_bits,
    output reg status_write_disable,
    output reg four_wire_command_mode,
    output reg [3:0] info_row_lock_bits,
    output reg reset_pin_disable,
    output reg erase_error_flag,
    output reg protection_error_flag,
    input wire err_clr
);
    localparam ST_IDLE = 3'b001;
    localparam ST_PROG = 3'b010;
    localparam ST_ERASE = 3'b100;

    function prot_hit;
        input [`FPE_AW-1:0] a;
        input [3:0] bp;
        reg [6:0] first_blk;
        begin
            first_blk = `FPE_NUM_BLK - (7'h01 << (bp - 4'h1));
            if (bp == 4'h0) begin
                prot_hit = 1'b0;
            end else if (bp >= `FPE_BP_ALL) begin
                prot_hit = 1'b1;
            end else begin
                prot_hit = ({1'b0, a[`FPE_BLK_HI:`FPE_BLK_LO]} >= first_blk);
            end
        end
    endfunction

    // synchronisers; stage one feeds stage two only
    reg cs_s1_r, cs_s2_r, cs_d_r;
    reg ck_s1_r, ck_s2_r, ck_d_r;
    reg [3:0] io_s1_r, io_s2_r;
    wire cs_rise = cs_s2_r & ~cs_d_r;
    wire ck_rise = ck_s2_r & ~ck_d_r & ~cs_s2_r;
    wire ck_fall = ~ck_s2_r & ck_d_r & ~cs_s2_r;

    reg [7:0] sh_r;
    reg [3:0] bit_cnt_r;
    reg [2:0] byte_idx_r;
    reg [7:0] opcode_r;
    reg [`FPE_AW-1:0] addr_r;
    reg [7:0] wptr_r;
    reg [7:0] buf_r [0:255];
    reg [255:0] mask_r;
    reg [2:0] state_r;
    reg [8:0] drain_r;
    reg [7:0] osh_r;
    reg [3:0] ocnt_r;
    reg rd_act_r;

    wire is_ppq = (opcode_r == `FPE_OP_PPQ_A) || (opcode_r == `FPE_OP_PPQ_B);
    wire wide = four_wire_command_mode || (is_ppq && byte_idx_r >= `FPE_IDX_DATA);
    wire [3:0] step = wide ? `FPE_STEP_WIDE : `FPE_STEP_NARROW;
    wire [7:0] byte_nxt = wide ? {sh_r[3:0], io_s2_r} : {sh_r[6:0], io_s2_r[0]};
    wire [3:0] cnt_sum = bit_cnt_r + step;
    wire byte_done = ck_rise && (cnt_sum == `FPE_BITS_BYTE);
    wire busy = (state_r != ST_IDLE);
    wire [7:0] status_val = {status_write_disable, quad_enable, block_protect_bits, write_enable_latch, busy};
    wire [7:0] func_val = {info_row_lock_bits, 2'b00, reset_pin_disable, 1'b0};
    wire [`FPE_AW-1:0] page_base = {addr_r[`FPE_AW-1:8], 8'h00};
    wire [`FPE_AW-1:0] region_mask = (opcode_r == `FPE_OP_BLK64) ? `FPE_B64_MASK :
        (opcode_r == `FPE_OP_BLK32) ? `FPE_B32_MASK : `FPE_SEC_MASK;

    wire fifo_in_ready, fifo_out_valid;
    wire [`FPE_AW+7:0] fifo_out_data;
    wire drain_more = (state_r == ST_PROG) && (drain_r < `FPE_PAGE_BYTES);
    wire drain_push = drain_more && mask_r[drain_r[7:0]];
    wire fifo_pop = fifo_out_valid && (~arr_wr_valid || arr_wr_ready);

    fpe_fifo #(
        .W(`FPE_AW + 8),
        .D(4),
        .AW(2)
    ) u_fifo (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .in_valid(drain_push),
        .in_ready(fifo_in_ready),
        .in_data({page_base[`FPE_AW-1:8], drain_r[7:0], buf_r[drain_r[7:0]]}),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_d_r <= 1'b1;
            ck_s1_r <= 1'b0;
            ck_s2_r <= 1'b0;
            ck_d_r <= 1'b0;
            io_s1_r <= 4'h0;
            io_s2_r <= 4'h0;
        end else begin
            cs_s1_r <= cs_n;
            cs_s2_r <= cs_s1_r;
            cs_d_r <= cs_s2_r;
            ck_s1_r <= sclk;
            ck_s2_r <= ck_s1_r;
            ck_d_r <= ck_s2_r;
            io_s1_r <= io_in;
            io_s2_r <= io_s1_r;
        end
    end

    // page buffer holds data only; the mask says which bytes are live
    always @(posedge core_clk) begin
        if (byte_done && is_ppq && byte_idx_r >= `FPE_IDX_DATA && !busy) begin
            buf_r[wptr_r] <= byte_nxt;
        end
    end

    // serial receive and read-back drive
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sh_r <= 8'h00;
            bit_cnt_r <= 4'h0;
            byte_idx_r <= 3'h0;
            opcode_r <= 8'h00;
            addr_r <= {`FPE_AW{1'b0}};
            wptr_r <= 8'h00;
            osh_r <= 8'h00;
            ocnt_r <= 4'h0;
            rd_act_r <= 1'b0;
            io_out <= 4'h0;
            io_oe <= `FPE_OE_NONE;
        end else if (cs_s2_r) begin
            // deselect aborts any partial byte and frees the pins
            bit_cnt_r <= 4'h0;
            byte_idx_r <= 3'h0;
            ocnt_r <= 4'h0;
            rd_act_r <= 1'b0;
            io_oe <= `FPE_OE_NONE;
        end else begin
            if (ck_rise) begin
                sh_r <= byte_nxt;
                bit_cnt_r <= byte_done ? 4'h0 : cnt_sum;
            end
            if (byte_done) begin
                if (byte_idx_r < `FPE_LEN_PROG_MIN) begin
                    byte_idx_r <= byte_idx_r + 3'h1;
                end
                if (byte_idx_r == 3'h0) begin
                    opcode_r <= byte_nxt;
                    rd_act_r <= (byte_nxt == `FPE_OP_RDST) || (byte_nxt == `FPE_OP_RDFN);
                end else if (byte_idx_r <= `FPE_IDX_ADDR2 && !busy) begin
                    addr_r <= {addr_r[`FPE_AW-9:0], byte_nxt};
                    if (byte_idx_r == `FPE_IDX_ADDR2) begin
                        wptr_r <= byte_nxt;
                    end
                end else if (is_ppq) begin
                    wptr_r <= wptr_r + 8'h01;
                end
            end
            if (ck_fall && rd_act_r) begin
                // value is refreshed at each byte so polling sees the busy bit drop
                if (ocnt_r == 4'h0) begin
                    if (four_wire_command_mode) begin
                        io_out <= (opcode_r == `FPE_OP_RDST) ? status_val[7:4] : func_val[7:4];
                        osh_r <= (opcode_r == `FPE_OP_RDST) ? {status_val[3:0], 4'h0} : {func_val[3:0], 4'h0};
                    end else begin
                        io_out <= {2'b00, ((opcode_r == `FPE_OP_RDST) ? status_val[7] : func_val[7]), 1'b0};
                        osh_r <= (opcode_r == `FPE_OP_RDST) ? {status_val[6:0], 1'b0} : {func_val[6:0], 1'b0};
                    end
                end else if (four_wire_command_mode) begin
                    io_out <= osh_r[7:4];
                    osh_r <= {osh_r[3:0], 4'h0};
                end else begin
                    io_out <= {2'b00, osh_r[7], 1'b0};
                    osh_r <= {osh_r[6:0], 1'b0};
                end
                ocnt_r <= ((ocnt_r + step) == `FPE_BITS_BYTE) ? 4'h0 : ocnt_r + step;
                io_oe <= four_wire_command_mode ? `FPE_OE_ALL : `FPE_OE_SO;
            end
        end
    end

    // mask of received page bytes
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mask_r <= 256'h0;
        end else if (byte_done && byte_idx_r == 3'h0 && !busy) begin
            mask_r <= 256'h0;
        end else if (byte_done && is_ppq && byte_idx_r >= `FPE_IDX_DATA && !busy) begin
            mask_r[wptr_r] <= 1'b1;
        end
    end

    // execution on select rise and self-timed operations
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ST_IDLE;
            drain_r <= 9'h000;
            write_enable_latch <= 1'b0;
            quad_enable <= 1'b0;
            block_protect_bits <= 4'h0;
            status_write_disable <= 1'b0;
            four_wire_command_mode <= 1'b0;
            info_row_lock_bits <= 4'h0;
            reset_pin_disable <= 1'b0;
            erase_error_flag <= 1'b0;
            protection_error_flag <= 1'b0;
            arr_erase_req <= 1'b0;
            arr_erase_base <= {`FPE_AW{1'b0}};
            arr_erase_mask <= {`FPE_AW{1'b0}};
            arr_wr_valid <= 1'b0;
            arr_wr_addr <= {`FPE_AW{1'b0}};
            arr_wr_data <= 8'h00;
            operation_in_progress <= 1'b0;
        end else begin
            operation_in_progress <= busy;
            if (fifo_pop) begin
                arr_wr_valid <= 1'b1;
                arr_wr_addr <= fifo_out_data[`FPE_AW+7:8];
                arr_wr_data <= fifo_out_data[7:0];
            end else if (arr_wr_ready) begin
                arr_wr_valid <= 1'b0;
            end
            if (err_clr) begin
                erase_error_flag <= 1'b0;
                protection_error_flag <= 1'b0;
            end
            case (state_r)
                ST_IDLE: begin
                    // bit count must be byte aligned or the command is dropped
                    if (cs_rise && bit_cnt_r == 4'h0) begin
                        case (opcode_r)
                            `FPE_OP_WLSET, `FPE_OP_WLCLR: begin
                                if (byte_idx_r == `FPE_LEN_OPCODE) begin
                                    write_enable_latch <= (opcode_r == `FPE_OP_WLSET);
                                end
                            end
                            `FPE_OP_QUAD_ON, `FPE_OP_QUAD_OFF: begin
                                if (byte_idx_r == `FPE_LEN_OPCODE) begin
                                    four_wire_command_mode <= (opcode_r == `FPE_OP_QUAD_ON);
                                end
                            end
                            `FPE_OP_WRST: begin
                                if (byte_idx_r == `FPE_LEN_REGWR && write_enable_latch) begin
                                    block_protect_bits <= addr_r[`FPE_SR_BP_HI:`FPE_SR_BP_LO];
                                    quad_enable <= addr_r[`FPE_SR_QE];
                                    status_write_disable <= addr_r[`FPE_SR_STATUS_WRITE_DISABLE];
                                    write_enable_latch <= 1'b0;
                                end
                            end
                            `FPE_OP_WRFN: begin
                                if (byte_idx_r == `FPE_LEN_REGWR && write_enable_latch) begin
                                    // one-time bits: ones are or-ed in, nothing returns to zero
                                    info_row_lock_bits <= info_row_lock_bits |
                                        addr_r[`FPE_FR_IRL_LO+3:`FPE_FR_IRL_LO];
                                    reset_pin_disable <= reset_pin_disable | addr_r[`FPE_FR_RSTDIS];
                                    write_enable_latch <= 1'b0;
                                end
                            end
                            `FPE_OP_PPQ_A, `FPE_OP_PPQ_B: begin
                                // quad program needs quad enable unless already in four-wire mode
                                if (byte_idx_r == `FPE_LEN_PROG_MIN && write_enable_latch &&
                                    (quad_enable || four_wire_command_mode) &&
                                    !prot_hit(addr_r, block_protect_bits)) begin
                                    state_r <= ST_PROG;
                                    drain_r <= 9'h000;
                                end
                            end
                            `FPE_OP_SEC_A, `FPE_OP_SEC_B, `FPE_OP_BLK32, `FPE_OP_BLK64: begin
                                if (byte_idx_r == `FPE_LEN_ADDR && write_enable_latch &&
                                    !prot_hit(addr_r, block_protect_bits)) begin
                                    state_r <= ST_ERASE;
                                    arr_erase_req <= 1'b1;
                                    arr_erase_mask <= region_mask;
                                    arr_erase_base <= addr_r & ~region_mask;
                                end
                            end
                            `FPE_OP_ALL_A, `FPE_OP_ALL_B: begin
                                if (byte_idx_r == `FPE_LEN_OPCODE && write_enable_latch) begin
                                    if (block_protect_bits == 4'h0) begin
                                        state_r <= ST_ERASE;
                                        arr_erase_req <= 1'b1;
                                        arr_erase_base <= {`FPE_AW{1'b0}};
                                        arr_erase_mask <= `FPE_ALL_MASK;
                                    end else begin
                                        erase_error_flag <= 1'b1;
                                        protection_error_flag <= 1'b1;
                                    end
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                ST_PROG: begin
                    // bytes with a clear mask are never sent, so the array keeps them
                    if (drain_more && (fifo_in_ready || !drain_push)) begin
                        drain_r <= drain_r + 9'h001;
                    end else if (!drain_more && !fifo_out_valid && !arr_wr_valid) begin
                        state_r <= ST_IDLE;
                        write_enable_latch <= 1'b0;
                    end
                end
                ST_ERASE: begin
                    if (arr_erase_done) begin
                        arr_erase_req <= 1'b0;
                        state_r <= ST_IDLE;
                        write_enable_latch <= 1'b0;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // fpe_cmd

`default_nettype wire

// ---- core/fpe_defines.vh ----
`ifndef FPE_DEFINES_VH
`define FPE_DEFINES_VH

// command opcodes
`define FPE_OP_PPQ_A 8'h32
`define FPE_OP_PPQ_B 8'h38
`define FPE_OP_SEC_A 8'hD7
`define FPE_OP_SEC_B 8'h20
`define FPE_OP_BLK32 8'h52
`define FPE_OP_BLK64 8'hD8
`define FPE_OP_ALL_A 8'hC7
`define FPE_OP_ALL_B 8'h60
`define FPE_OP_WLSET 8'h06
`define FPE_OP_WLCLR 8'h04
`define FPE_OP_RDST 8'h05
`define FPE_OP_WRST 8'h01
`define FPE_OP_RDFN 8'h48
`define FPE_OP_WRFN 8'h42
`define FPE_OP_QUAD_ON 8'h35
`define FPE_OP_QUAD_OFF 8'hF5

// command framing, counted in bytes including the opcode
`define FPE_IDX_ADDR0 3'h1
`define FPE_IDX_ADDR2 3'h3
`define FPE_IDX_DATA 3'h4
`define FPE_LEN_OPCODE 3'h1
`define FPE_LEN_REGWR 3'h2
`define FPE_LEN_ADDR 3'h4
`define FPE_LEN_PROG_MIN 3'h5
`define FPE_BITS_BYTE 4'h8
`define FPE_STEP_WIDE 4'h4
`define FPE_STEP_NARROW 4'h1

// array geometry
`define FPE_AW 22
`define FPE_PAGE_BYTES 9'h100
`define FPE_SEC_MASK 22'h000FFF
`define FPE_B32_MASK 22'h007FFF
`define FPE_B64_MASK 22'h00FFFF
`define FPE_ALL_MASK 22'h3FFFFF
`define FPE_BLK_HI 21
`define FPE_BLK_LO 16
`define FPE_NUM_BLK 7'h40
`define FPE_BP_ALL 4'h7

// status register layout
`define FPE_SR_WIP 0
`define FPE_SR_WEL 1
`define FPE_SR_BP_LO 2
`define FPE_SR_BP_HI 5
`define FPE_SR_QE 6
`define FPE_SR_STATUS_WRITE_DISABLE 7
`define FPE_SR_RESET 8'h00

// function register layout, one-time bits only
`define FPE_FR_RSTDIS 1
`define FPE_FR_IRL_LO 4
`define FPE_FR_OTP_MASK 8'hF2
`define FPE_FR_RESET 8'h00

// pin drive patterns
`define FPE_OE_NONE 4'h0
`define FPE_OE_SO 4'h2
`define FPE_OE_ALL 4'hF

`endif

// ---- core/fpe_fifo.v ----
`timescale 1ns/1ps
`default_nettype none

module fpe_fifo #(
    parameter W = 30,
    parameter D = 4,
    parameter AW = 2
) (
    // clock and reset
    input wire core_clk,
    input wire arst_n,
    // filling side
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    // draining side
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);
    reg [W-1:0] mem_r [0:D-1];
    reg [AW-1:0] wp_r;
    reg [AW-1:0] rp_r;
    reg [AW:0] cnt_r;
    reg full_r;
    reg empty_r;
    wire push;
    wire pop;
    reg [AW:0] cnt_nxt;

    assign in_ready = ~full_r;
    assign out_valid = ~empty_r;
    assign out_data = mem_r[rp_r];
    assign push = in_valid & ~full_r;
    assign pop = out_ready & ~empty_r;

    always @* begin
        cnt_nxt = cnt_r;
        if (push & ~pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop & ~push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always @(posedge core_clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wp_r <= {AW{1'b0}};
            rp_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
            full_r <= 1'b0;
            empty_r <= 1'b1;
        end else begin
            if (push) begin
                wp_r <= (wp_r == D - 1) ? {AW{1'b0}} : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == D - 1) ? {AW{1'b0}} : rp_r + 1'b1;
            end
            cnt_r <= cnt_nxt;
            full_r <= (cnt_nxt == D);
            empty_r <= (cnt_nxt == {(AW+1){1'b0}});
        end
    end
endmodule // fpe_fifo

`default_nettype wire

// ---- tb/fpe_cmd_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fpe_defines.vh"
module fpe_cmd_checker (
    // clock, reset, select
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic cs_n,
    // array ports
    input wire logic arr_wr_valid,
    input wire logic arr_wr_ready,
    input wire logic [`FPE_AW-1:0] arr_wr_addr,
    input wire logic [7:0] arr_wr_data,
    input wire logic arr_erase_req,
    input wire logic [`FPE_AW-1:0] arr_erase_base,
    input wire logic [`FPE_AW-1:0] arr_erase_mask,
    input wire logic arr_erase_done,
    // status view
    input wire logic operation_in_progress,
    input wire logic write_enable_latch,
    input wire logic [3:0] block_protect_bits,
    input wire logic [3:0] info_row_lock_bits
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // request drops, then busy and latch both settle low
    sequence s_erase_end;
        ##1 !arr_erase_req ##[0:2] (!operation_in_progress && !write_enable_latch);
    endsequence
    erase_hold_a: assert property (arr_erase_req && !arr_erase_done |=> arr_erase_req)
        else $error("erase request dropped early");
    erase_end_a: assert property (arr_erase_req && arr_erase_done |-> s_erase_end)
        else $error("erase end not clean");
    wr_hold_a: assert property (arr_wr_valid && !arr_wr_ready |=>
        arr_wr_valid && $stable({arr_wr_addr, arr_wr_data}))
        else $error("program byte not held");
    erase_busy_a: assert property ($rose(arr_erase_req) |=> operation_in_progress)
        else $error("busy low during erase");
    erase_cs_a: assert property ($rose(arr_erase_req) |-> cs_n && $past(write_enable_latch))
        else $error("erase started without select rise or latch");
    erase_align_a: assert property (arr_erase_req |-> (arr_erase_base & arr_erase_mask) == 22'h0)
        else $error("erase base not aligned");
    chip_unprot_a: assert property (arr_erase_req && arr_erase_mask == `FPE_ALL_MASK |->
        block_protect_bits == 4'h0)
        else $error("whole erase while protected");
    lock_otp_a: assert property (($past(info_row_lock_bits) & ~info_row_lock_bits) == 4'h0)
        else $error("lock bit cleared");
endmodule // fpe_cmd_checker
bind fpe_cmd fpe_cmd_checker i_chk (.*);
`default_nettype wire

// ---- tb/fpe_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module fpe_host_model (
    // clock
    input wire logic core_clk,
    // link pins
    output logic cs_n,
    output logic sclk,
    output logic [3:0] io_in,
    input wire logic [3:0] io_out
);
    logic [7:0] tx [$];
    logic [7:0] rx = 8'h00;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        io_in = 4'h0;
    end
    task automatic half;
        repeat (4) @(posedge core_clk);
        #5;
    endtask
    // bytes from index nq on go as two nibbles, high first
    task automatic frame(input int nq);
        half;
        cs_n = 1'b0;
        for (int i = 0; i < tx.size(); i++) begin
            for (int k = (i < nq) ? 7 : 1; k >= 0; k--) begin
                io_in = (i < nq) ? {~io_in[3:1], tx[i][k]} : tx[i][4*k +: 4];
                half;
                sclk = 1'b1;
                rx = {rx[6:0], io_out[1]};
                half;
                sclk = 1'b0;
            end
        end
        half;
        cs_n = 1'b1;
        io_in = ~io_in; // released lines must not look held
        half;
    endtask
endmodule // fpe_host_model
`default_nettype wire

// ---- tb/fpe_cmd_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fpe_defines.vh"
module fpe_cmd_tb_top;
    logic core_clk, arst_n, cs_n, sclk, err_clr, arr_wr_ready, arr_erase_done, req_d = 1'b0;
    logic [3:0] io_in, io_out, io_oe, block_protect_bits, info_row_lock_bits;
    logic arr_wr_valid, arr_erase_req, operation_in_progress, write_enable_latch, quad_enable;
    logic status_write_disable, four_wire_command_mode, reset_pin_disable, erase_error_flag, protection_error_flag;
    logic [`FPE_AW-1:0] arr_wr_addr, arr_erase_base, arr_erase_mask;
    logic [7:0] arr_wr_data;
    logic [43:0] expq [$];
    logic [31:0] rnd = 32'h42015EC5;
    logic [7:0] eops [6] = '{8'hD7, 8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};
    logic [21:0] emsk [6] = '{22'h000FFF, 22'h000FFF, 22'h007FFF, 22'h00FFFF, 22'h3FFFFF, 22'h3FFFFF};
    int n_fail = 0;
    int total_checks = 0;
    fpe_cmd i_fpe_cmd (.*);
    fpe_host_model h (.core_clk, .cs_n, .sclk, .io_in, .io_out);
    function automatic [31:0] step(input [31:0] s);
        step = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // array stand-in accepts slowly so a status poll sees busy
    always @(posedge core_clk) begin
        #5;
        rnd = step(rnd);
        arr_wr_ready = rnd[0] & rnd[1];
        arr_erase_done = arr_erase_req & !arr_erase_done & (rnd[4:2] == 3'h0);
    end
    task automatic check(input [43:0] got, input [43:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic pop(input [43:0] got);
        check(got, (expq.size() == 0) ? 44'hFFFFFFFFFFF : expq.pop_front());
    endtask
    always @(posedge core_clk) begin
        if (arr_wr_valid && arr_wr_ready)
            pop({arr_wr_addr, 14'h0, arr_wr_data});
        if (arr_erase_req && !req_d)
            pop({arr_erase_base, arr_erase_mask});
        req_d <= arr_erase_req;
    end
    task automatic cmd(input [7:0] op, input [7:0] d, input int n);
        h.tx = {op, d};
        if (n == 1)
            h.tx.delete(1);
        h.frame(99);
    endtask
    task automatic rd(input [7:0] op, input [7:0] exp);
        cmd(op, 8'h00, 2);
        check({36'h0, h.rx}, {36'h0, exp});
    endtask
    task automatic idle;
        for (int i = 0; i < 4000 && operation_in_progress !== 1'b0; i++) @(posedge core_clk);
        repeat (8) @(posedge core_clk);
    endtask
    task automatic prog(input [21:0] a, input int n, input bit ok);
        bit live [0:255];
        logic [7:0] m [0:255];
        h.tx = {8'h32, 8'(a >> 16), 8'(a >> 8), 8'(a)};
        for (int j = 0; j < n; j++) begin
            rnd = step(rnd);
            h.tx.push_back(rnd[7:0]);
            m[8'(a + j)] = rnd[7:0];
            live[8'(a + j)] = 1'b1;
        end
        for (int o = 0; o < 256; o++)
            if (ok && live[o])
                expq.push_back({a[21:8], 8'(o), 14'h0, m[o]});
        h.frame(4);
    endtask
    task automatic conclude;
        $display("checks=%0d mismatches=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #3000000;
        n_fail++;
        conclude;
    end
    initial begin
        arst_n = 1'b0;
        err_clr = 1'b0;
        arr_wr_ready = 1'b0;
        arr_erase_done = 1'b0;
        repeat (6) @(posedge core_clk);
        #5 arst_n = 1'b1;
        repeat (4) @(posedge core_clk);
        rd(8'h05, 8'h00);
        cmd(8'h06, 8'h00, 1);
        cmd(8'h01, 8'h40, 2);
        rd(8'h05, 8'h40);
        prog(22'h001200, 2, 0);
        cmd(8'h06, 8'h00, 1);
        cmd(8'h04, 8'h00, 1);
        prog(22'h001200, 2, 0);
        $display("test latch done");
        cmd(8'h06, 8'h00, 1);
        prog(22'h001210, 260, 1);
        rd(8'h05, 8'h43);
        idle;
        cmd(8'h06, 8'h00, 1);
        prog(22'h0013FE, 3, 1);
        idle;
        rd(8'h05, 8'h40);
        $display("test program done");
        for (int e = 0; e < 6; e++) begin
            cmd(8'h06, 8'h00, 1);
            expq.push_back({22'h012345 & ~emsk[e], emsk[e]});
            h.tx = {eops[e], 8'h01, 8'h23, 8'h45};
            if (e > 3)
                h.tx = {eops[e]};
            h.frame(99);
            idle;
            rd(8'h05, 8'h40);
        end
        $display("test erase done");
        cmd(8'h06, 8'h00, 1);
        cmd(8'h01, 8'h5C, 2);
        cmd(8'h06, 8'h00, 1);
        prog(22'h001200, 2, 0);
        rd(8'h05, 8'h5E);
        cmd(8'hC7, 8'h00, 1);
        repeat (4) @(posedge core_clk);
        check({42'h0, erase_error_flag, protection_error_flag}, 44'h3);
        #5 err_clr = 1'b1;
        @(posedge core_clk);
        #5 err_clr = 1'b0;
        repeat (2) @(posedge core_clk);
        check({42'h0, erase_error_flag, protection_error_flag}, 44'h0);
        cmd(8'h06, 8'h00, 1);
        cmd(8'h01, 8'h40, 2);
        for (int f = 0; f < 2; f++) begin
            cmd(8'h06, 8'h00, 1);
            cmd(8'h42, f ? 8'h00 : 8'hF2, 2);
            rd(8'h48, 8'hF2);
        end
        cmd(8'h06, 8'h00, 1);
        h.tx = {8'hD8, 8'h01, 8'h00};
        h.frame(99);
        rd(8'h05, 8'h42);
        check(44'(expq.size()), 44'h0);
        cmd(8'h35, 8'h00, 1);
        check(44'(four_wire_command_mode), 44'h1);
        h.tx = {8'hF5};
        h.frame(0);
        check(44'(four_wire_command_mode), 44'h0);
        $display("test protect done");
        conclude;
    end
endmodule // fpe_cmd_tb_top
`default_nettype wire
